//--- ivps_ctrl.sv
/*
  Interrupt controller with vector generation, two priority levels with
  preemption, and the three-entry register-page stack.
  Assumes peripheral flags and core handshakes are on clk; the core holds
  vec_ack for one cycle to take the offered vector and pulses
  handler_return when a handler ends.
*/
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ivps_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [ivps_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ivps_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ivps_pkg::DATA_W-1:0] reg_rdata,
  // peripheral pending flags
  input wire logic ext_irq0_flag,
  input wire logic timer0_overflow_flag,
  input wire logic ext_irq1_flag,
  input wire logic timer1_overflow_flag,
  input wire logic uart_receive_flag,
  input wire logic uart_transmit_flag,
  input wire logic timer2_high_overflow_flag,
  input wire logic timer2_low_overflow_flag,
  input wire logic spi_transfer_done_flag,
  input wire logic spi_write_collision_flag,
  input wire logic spi_mode_fault_flag,
  input wire logic spi_rx_overrun_flag,
  input wire logic smbus_flag,
  input wire logic adc_window_flag,
  input wire logic adc_done_flag,
  input wire logic counter_array_flag,
  input wire logic comparator0_flag,
  input wire logic comparator1_flag,
  input wire logic timer3_high_overflow_flag,
  input wire logic timer3_low_overflow_flag,
  input wire logic lin_pending_flag,
  input wire logic can_pending_flag,
  // flagless requests
  input wire logic regulator_dropout_req,
  input wire logic port_match_req,
  // hardware flag clear, one pulse per source in HW_CLR_MASK
  output logic [ivps_pkg::NUM_SRC-1:0] hw_flag_clear,
  // core handshake
  output logic vec_req,
  output logic [15:0] vec_addr,
  output logic [ivps_pkg::IDX_W-1:0] vec_src,
  output logic vec_high,
  input wire logic vec_ack,
  input wire logic handler_return,
  // page stack
  output logic [7:0] active_page_reg,
  output logic [7:0] page_stack_level2,
  output logic [7:0] page_stack_bottom,
  // interrupt
  output logic irq
);

  // ==========================================================
  // registers
  logic [6:0] basic_enable_reg_q;
  logic [6:0] basic_priority_reg_q;
  logic [7:0] extended_enable_reg1_q;
  logic [7:0] extended_priority_reg1_q;
  logic [2:0] extended_enable_reg2_q;
  logic [2:0] extended_priority_reg2_q;
  logic [7:0] active_page_q;
  logic [7:0] page_lvl2_q;
  logic [7:0] page_bottom_q;
  logic [2:0] evt_status_q;
  logic [2:0] evt_enable_q;
  logic [7:0] rdata_q;
  logic vec_req_q;
  logic [15:0] vec_addr_q;
  logic [ivps_pkg::IDX_W-1:0] vec_src_q;
  logic vec_high_q;
  logic in_low_q;
  logic in_high_q;
  logic [ivps_pkg::NUM_SRC-1:0] hw_clear_q;

  // ==========================================================
  // request gathering
  logic [ivps_pkg::NUM_SRC-1:0] src_req;
  logic [ivps_pkg::NUM_SRC-1:0] en_all;
  logic [ivps_pkg::NUM_SRC-1:0] pri_all;
  logic [ivps_pkg::NUM_SRC-1:0] req_high;
  logic [ivps_pkg::NUM_SRC-1:0] req_low;
  logic high_found;
  logic low_found;
  logic [ivps_pkg::IDX_W-1:0] high_idx;
  logic [ivps_pkg::IDX_W-1:0] low_idx;
  logic take_high;
  logic take_low;
  logic [ivps_pkg::IDX_W-1:0] next_src;
  logic acked;
  logic popped;

  always_comb begin
    src_req[0] = ext_irq0_flag;
    src_req[1] = timer0_overflow_flag;
    src_req[2] = ext_irq1_flag;
    src_req[3] = timer1_overflow_flag;
    src_req[4] = uart_receive_flag | uart_transmit_flag;
    src_req[5] = timer2_high_overflow_flag | timer2_low_overflow_flag;
    src_req[6] = spi_transfer_done_flag | spi_write_collision_flag
               | spi_mode_fault_flag | spi_rx_overrun_flag;
    src_req[7] = smbus_flag;
    src_req[8] = adc_window_flag;
    src_req[9] = adc_done_flag;
    src_req[10] = counter_array_flag;
    src_req[11] = comparator0_flag;
    src_req[12] = comparator1_flag;
    src_req[13] = timer3_high_overflow_flag | timer3_low_overflow_flag;
    // never cleared here; the LIN block drops it on its own reset bit
    src_req[14] = lin_pending_flag;
    src_req[15] = regulator_dropout_req;
    src_req[16] = can_pending_flag;
    src_req[17] = port_match_req;
  end

  assign en_all = {extended_enable_reg2_q, extended_enable_reg1_q, basic_enable_reg_q};
  assign pri_all = {extended_priority_reg2_q, extended_priority_reg1_q, basic_priority_reg_q};
  assign req_high = src_req & en_all & pri_all;
  assign req_low = src_req & en_all & ~pri_all;

  // lowest number wins inside each level
  ivps_first_set #(.N(ivps_pkg::NUM_SRC), .W(ivps_pkg::IDX_W)) u_high_pick (
    .req(req_high),
    .found(high_found),
    .idx(high_idx)
  );
  ivps_first_set #(.N(ivps_pkg::NUM_SRC), .W(ivps_pkg::IDX_W)) u_low_pick (
    .req(req_low),
    .found(low_found),
    .idx(low_idx)
  );
  // high may cut into a low handler, never into another high one
  assign take_high = high_found && !in_high_q;
  assign take_low = low_found && !in_high_q && !in_low_q;
  assign next_src = take_high ? high_idx : low_idx;
  assign acked = vec_ack && vec_req_q;
  // an ack in the same cycle wins and that return is dropped; the core never issues both
  assign popped = handler_return && !acked && (in_low_q || in_high_q);

  // ==========================================================
  // vector offer, refreshed each cycle until the core takes it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vec_req_q <= 1'b0;
      vec_addr_q <= ivps_pkg::RESET_VECTOR;
      vec_src_q <= '0;
      vec_high_q <= 1'b0;
    end else if (acked) begin
      vec_req_q <= 1'b0;
    end else begin
      vec_req_q <= take_high || take_low;
      vec_high_q <= take_high;
      vec_src_q <= next_src;
      vec_addr_q <= ivps_pkg::VEC_BASE
                  + {8'h00, next_src, 3'b000};
    end
  end

  // ==========================================================
  // in-service levels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_low_q <= 1'b0;
      in_high_q <= 1'b0;
    end else if (acked) begin
      in_high_q <= in_high_q || vec_high_q;
      in_low_q <= in_low_q || !vec_high_q;
    end else if (popped) begin
      in_high_q <= 1'b0;
      in_low_q <= in_low_q && in_high_q;
    end
  end

  // ==========================================================
  // hardware flag clear pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hw_clear_q <= '0;
    end else if (acked) begin
      hw_clear_q <= (ivps_pkg::NUM_SRC'(1) << vec_src_q) & ivps_pkg::HW_CLR_MASK;
    end else begin
      hw_clear_q <= '0;
    end
  end

  // ==========================================================
  // page stack; hardware push and pop win over a software write
  logic [7:0] src_page;
  always_comb begin
    unique case (vec_src_q)
      ivps_pkg::SRC_CAN: src_page = ivps_pkg::PAGE_CAN;
      ivps_pkg::SRC_LIN: src_page = ivps_pkg::PAGE_LIN;
      default: src_page = ivps_pkg::PAGE_DEFAULT;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_page_q <= ivps_pkg::PAGE_RESET;
      page_lvl2_q <= ivps_pkg::PAGE_RESET;
      page_bottom_q <= ivps_pkg::PAGE_RESET;
    end else if (acked) begin
      active_page_q <= src_page;
      page_lvl2_q <= active_page_q;
      // old bottom is simply lost; no fourth level exists
      page_bottom_q <= page_lvl2_q;
    end else if (popped) begin
      active_page_q <= page_lvl2_q;
      page_lvl2_q <= page_bottom_q;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ivps_pkg::OFS_ACTIVE_PAGE: active_page_q <= reg_wdata;
        ivps_pkg::OFS_PAGE_LVL2: page_lvl2_q <= reg_wdata;
        ivps_pkg::OFS_PAGE_BOTTOM: page_bottom_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // enable and priority registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      basic_enable_reg_q <= ivps_pkg::REG_RESET[6:0];
      basic_priority_reg_q <= ivps_pkg::REG_RESET[6:0];
      extended_enable_reg1_q <= ivps_pkg::REG_RESET;
      extended_priority_reg1_q <= ivps_pkg::REG_RESET;
      extended_enable_reg2_q <= ivps_pkg::REG_RESET[2:0];
      extended_priority_reg2_q <= ivps_pkg::REG_RESET[2:0];
      evt_enable_q <= ivps_pkg::REG_RESET[2:0];
    end else if (reg_wr) begin
      unique case (reg_addr)
        ivps_pkg::OFS_BASIC_EN: basic_enable_reg_q <= reg_wdata[6:0];
        ivps_pkg::OFS_BASIC_PRI: basic_priority_reg_q <= reg_wdata[6:0];
        ivps_pkg::OFS_EXT_EN1: extended_enable_reg1_q <= reg_wdata;
        ivps_pkg::OFS_EXT_PRI1: extended_priority_reg1_q <= reg_wdata;
        ivps_pkg::OFS_EXT_EN2: extended_enable_reg2_q <= reg_wdata[2:0];
        ivps_pkg::OFS_EXT_PRI2: extended_priority_reg2_q <= reg_wdata[2:0];
        ivps_pkg::OFS_EVT_ENABLE: evt_enable_q <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // event status: sticky, set beats a same-cycle clear
  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  always_comb begin
    evt_set = '0;
    evt_set[ivps_pkg::EVT_VECTORED] = acked;
    evt_set[ivps_pkg::EVT_PREEMPTED] = acked && vec_high_q && in_low_q;
    evt_set[ivps_pkg::EVT_STRAY_RET] = handler_return && !acked && !in_low_q && !in_high_q;
    evt_clr = '0;
    if (reg_wr && reg_addr == ivps_pkg::OFS_EVT_CLEAR) begin
      evt_clr = reg_wdata[2:0];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evt_status_q <= ivps_pkg::REG_RESET[2:0];
    end else begin
      evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
    end
  end

  // ==========================================================
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ivps_pkg::OFS_BASIC_EN: rdata_q <= {1'b0, basic_enable_reg_q};
        ivps_pkg::OFS_BASIC_PRI: rdata_q <= {1'b0, basic_priority_reg_q};
        ivps_pkg::OFS_EXT_EN1: rdata_q <= extended_enable_reg1_q;
        ivps_pkg::OFS_EXT_PRI1: rdata_q <= extended_priority_reg1_q;
        ivps_pkg::OFS_EXT_EN2: rdata_q <= {5'h00, extended_enable_reg2_q};
        ivps_pkg::OFS_EXT_PRI2: rdata_q <= {5'h00, extended_priority_reg2_q};
        ivps_pkg::OFS_ACTIVE_PAGE: rdata_q <= active_page_q;
        ivps_pkg::OFS_PAGE_LVL2: rdata_q <= page_lvl2_q;
        ivps_pkg::OFS_PAGE_BOTTOM: rdata_q <= page_bottom_q;
        ivps_pkg::OFS_EVT_STATUS: rdata_q <= {5'h00, evt_status_q};
        ivps_pkg::OFS_EVT_ENABLE: rdata_q <= {5'h00, evt_enable_q};
        ivps_pkg::OFS_SERVICE: rdata_q <= {6'h00, in_high_q, in_low_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = rdata_q;
  assign hw_flag_clear = hw_clear_q;
  assign vec_req = vec_req_q;
  assign vec_addr = vec_addr_q;
  assign vec_src = vec_src_q;
  assign vec_high = vec_high_q;
  assign active_page_reg = active_page_q;
  assign page_stack_level2 = page_lvl2_q;
  assign page_stack_bottom = page_bottom_q;
  assign irq = |(evt_status_q & evt_enable_q);

  // ==========================================================
  // checks
  chk_reset_vector: assert property (@(posedge clk)
    sys_rst |=> (!vec_req_q && vec_addr_q == ivps_pkg::RESET_VECTOR))
    else $error("offer after reset is not the idle reset vector");
  chk_vector_map: assert property (@(posedge clk) disable iff (sys_rst)
    vec_req_q |-> (vec_addr_q == ivps_pkg::VEC_BASE + {8'h00, vec_src_q, 3'b000}
                   && vec_addr_q <= ivps_pkg::VEC_LAST))
    else $error("vector address does not match source");
  chk_natural_order: assert property (@(posedge clk) disable iff (sys_rst)
    (!acked && take_low && !take_high)
      |=> (vec_src_q == $past(low_idx) && !(|($past(req_low) & ((18'h1 << vec_src_q) - 18'h1)))))
    else $error("low request not resolved to lowest source");
  chk_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (!acked && (take_high || take_low)) |=> (vec_req_q && $past(en_all[next_src])))
    else $error("disabled source offered");
  chk_hw_clear: assert property (@(posedge clk) disable iff (sys_rst)
    acked |=> (hw_clear_q == ((18'h1 << $past(vec_src_q)) & ivps_pkg::HW_CLR_MASK)) ##1 (hw_clear_q == '0))
    else $error("hardware flag clear pulse wrong");
  chk_preempt: assert property (@(posedge clk) disable iff (sys_rst)
    (in_low_q && !in_high_q && high_found && !vec_req_q && !popped)
      |=> (vec_req_q && vec_high_q))
    else $error("high request failed to preempt low handler");
  chk_page_push: assert property (@(posedge clk) disable iff (sys_rst)
    acked |=> (active_page_q == $past(src_page) && page_lvl2_q == $past(active_page_q)
               && page_bottom_q == $past(page_lvl2_q)))
    else $error("page stack push wrong");
  chk_page_pop: assert property (@(posedge clk) disable iff (sys_rst)
    popped |=> (active_page_q == $past(page_lvl2_q) && page_lvl2_q == $past(page_bottom_q)))
    else $error("page stack pop wrong");
  chk_same_level: assert property (@(posedge clk) disable iff (sys_rst)
    (in_high_q || in_low_q && !high_found) |=> !vec_req_q || $past(popped))
    else $error("request offered against running handler");

endmodule

`default_nettype wire

//--- ivps_pkg.sv
/*
  Constants shared by the interrupt controller: register offsets, field
  masks, reset values, vector layout and the page each source lives on.
  Assumes an 8-bit register port and 18 maskable sources.
*/
package ivps_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned NUM_SRC = 18;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // ==========================================================
  // vectors
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_LAST = 16'h008b;
  localparam int unsigned VEC_STEP_SHIFT = 3;
  localparam logic [IDX_W-1:0] SRC_DROPOUT = 5'h0f;
  localparam logic [IDX_W-1:0] SRC_LIN = 5'h0e;
  localparam logic [IDX_W-1:0] SRC_CAN = 5'h10;
  localparam logic [IDX_W-1:0] SRC_PORT_MATCH = 5'h11;

  // flags cleared by hardware on vectoring: ext0, t0, ext1, t1, can
  localparam logic [NUM_SRC-1:0] HW_CLR_MASK = 18'h1000f;

  // ==========================================================
  // page that holds each source's registers
  localparam logic [7:0] PAGE_DEFAULT = 8'h00;
  localparam logic [7:0] PAGE_LIN = 8'h0f;
  localparam logic [7:0] PAGE_CAN = 8'h0c;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_BASIC_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_BASIC_PRI = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_EXT_EN1 = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_EXT_EN2 = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_EXT_PRI1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EXT_PRI2 = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE_PAGE = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_PAGE_LVL2 = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_PAGE_BOTTOM = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 8'h0a;
  localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 8'h0b;
  localparam logic [ADDR_W-1:0] OFS_SERVICE = 8'h0c;

  // ==========================================================
  // field masks (reserved bits read zero, writes dropped)
  localparam logic [DATA_W-1:0] BASIC_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] EXT1_MASK = 8'hff;
  localparam logic [DATA_W-1:0] EXT2_MASK = 8'h07;
  localparam logic [DATA_W-1:0] EVT_MASK = 8'h07;
  localparam int unsigned EVT_VECTORED = 0;
  localparam int unsigned EVT_PREEMPTED = 1;
  localparam int unsigned EVT_STRAY_RET = 2;
  localparam int unsigned SVC_LOW_BIT = 0;
  localparam int unsigned SVC_HIGH_BIT = 1;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;

endpackage

//--- ivps_first_set.sv
/*
  Finds the lowest-numbered set bit of a request vector.
  Assumes the caller checks found before using idx.
*/
`timescale 1ns/1ns
`default_nettype none

module ivps_first_set #(
  parameter int unsigned N = 18,
  parameter int unsigned W = 5
) (
  // request vector
  input wire logic [N-1:0] req,
  // result
  output logic found,
  output logic [W-1:0] idx
);

  // ==========================================================
  // scan from the top so the lowest index is written last
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule

`default_nettype wire

//--- ivps_core_model.sv
/*
  Processor core stand-in: takes offered vectors after a set wait.
  Assumes the vector offer is registered on clk.
*/
`timescale 1ns/1ns
`default_nettype none

module ivps_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // offer
  input wire logic vec_req,
  input wire logic [15:0] vec_addr,
  input wire logic vec_high,
  input wire logic [3:0] ack_wait,
  // answer
  output logic vec_ack,
  output logic [15:0] took_addr,
  output logic took_high,
  output logic [7:0] took_cnt
);
  logic [3:0] wait_q;

  // ==========================================
  // handshake
  // a late ack lets a better offer replace the first one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vec_ack <= 1'b0;
      wait_q <= 4'h0;
      took_cnt <= 8'h00;
      took_addr <= 16'h0000;
      took_high <= 1'b0;
    end else if (vec_ack) begin
      vec_ack <= 1'b0;
      if (vec_req) begin
        took_addr <= vec_addr;
        took_high <= vec_high;
        took_cnt <= took_cnt + 8'h01;
      end
    end else if (vec_req && wait_q >= ack_wait) begin
      vec_ack <= 1'b1;
      wait_q <= 4'h0;
    end else if (vec_req) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule

`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench for the interrupt controller.
  Assumes the core model answers vectors; the bench plays software.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic clk, sys_rst, reg_wr, reg_rd, vec_req, vec_high, vec_ack, handler_return, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, took_cnt;
  logic [7:0] active_page_reg, page_stack_level2, page_stack_bottom, ea, el, eb;
  logic [23:0] fl;
  logic [17:0] hw_flag_clear, en_v, pri_v;
  logic [15:0] vec_addr, took_addr;
  logic [4:0] vec_src;
  logic [3:0] ack_wait;
  logic took_high;
  int num_errors, checked, cyc;
  // first flag of each source in source number order
  localparam int FB [18] = '{0, 1, 2, 3, 4, 6, 8, 12, 13, 14, 15, 16, 17, 18, 20, 22, 21, 23};

  ivps_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq0_flag(fl[0]), .timer0_overflow_flag(fl[1]), .ext_irq1_flag(fl[2]),
    .timer1_overflow_flag(fl[3]), .uart_receive_flag(fl[4]), .uart_transmit_flag(fl[5]),
    .timer2_high_overflow_flag(fl[6]), .timer2_low_overflow_flag(fl[7]),
    .spi_transfer_done_flag(fl[8]), .spi_write_collision_flag(fl[9]),
    .spi_mode_fault_flag(fl[10]), .spi_rx_overrun_flag(fl[11]), .smbus_flag(fl[12]),
    .adc_window_flag(fl[13]), .adc_done_flag(fl[14]), .counter_array_flag(fl[15]),
    .comparator0_flag(fl[16]), .comparator1_flag(fl[17]), .timer3_high_overflow_flag(fl[18]),
    .timer3_low_overflow_flag(fl[19]), .lin_pending_flag(fl[20]), .can_pending_flag(fl[21]),
    .regulator_dropout_req(fl[22]), .port_match_req(fl[23]), .hw_flag_clear(hw_flag_clear),
    .vec_req(vec_req), .vec_addr(vec_addr), .vec_src(vec_src), .vec_high(vec_high),
    .vec_ack(vec_ack), .handler_return(handler_return), .active_page_reg(active_page_reg),
    .page_stack_level2(page_stack_level2), .page_stack_bottom(page_stack_bottom), .irq(irq));

  ivps_core_model core (.clk(clk), .sys_rst(sys_rst), .vec_req(vec_req), .vec_addr(vec_addr),
    .vec_high(vec_high), .ack_wait(ack_wait), .vec_ack(vec_ack), .took_addr(took_addr),
    .took_high(took_high), .took_cnt(took_cnt));

  always #50 clk = ~clk;

  // ==========================================
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      final_report();
    end
  end

  // ==========================================
  // helpers
  task automatic final_report();
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) begin
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
    end
    @(posedge clk) reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk) begin
      reg_addr <= a;
      reg_rd <= 1'b1;
    end
    @(posedge clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cfg();
    wr(ivps_pkg::OFS_BASIC_EN, {1'b0, en_v[6:0]});
    wr(ivps_pkg::OFS_EXT_EN1, en_v[14:7]);
    wr(ivps_pkg::OFS_EXT_EN2, {5'h00, en_v[17:15]});
    wr(ivps_pkg::OFS_BASIC_PRI, {1'b0, pri_v[6:0]});
    wr(ivps_pkg::OFS_EXT_PRI1, pri_v[14:7]);
    wr(ivps_pkg::OFS_EXT_PRI2, {5'h00, pri_v[17:15]});
  endtask

  function automatic logic [7:0] pg(input int n);
    if (n == ivps_pkg::SRC_CAN) return ivps_pkg::PAGE_CAN;
    if (n == ivps_pkg::SRC_LIN) return ivps_pkg::PAGE_LIN;
    return ivps_pkg::PAGE_DEFAULT;
  endfunction

  task automatic pages();
    chk("active", active_page_reg, ea);
    chk("level2", page_stack_level2, el);
    chk("bottom", page_stack_bottom, eb);
  endtask

  // waits for a taken vector, then checks the push
  task automatic take(input logic [7:0] c0, input int n);
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      #1;
      if (took_cnt !== c0) break;
    end
    chk("taken", took_cnt, c0 + 8'h01);
    eb = el;
    el = ea;
    ea = pg(n);
    pages();
    chk("vec_addr", took_addr, ivps_pkg::VEC_BASE + (n << 3));
    chk("vec_src", vec_src, n[4:0]);
    chk("hw_clear", hw_flag_clear, ivps_pkg::HW_CLR_MASK & (18'h1 << n));
  endtask

  task automatic ret();
    @(posedge clk) handler_return <= 1'b1;
    @(posedge clk) handler_return <= 1'b0;
    #1;
    ea = el;
    el = eb;
    pages();
  endtask

  task automatic vec(input int n, input int b);
    en_v = 18'h0;
    en_v[n] = 1'b1;
    cfg();
    ack_wait <= 4'(n % 4);
    @(posedge clk) fl[b] <= 1'b1;
    take(took_cnt, n);
    @(posedge clk) fl[b] <= 1'b0;
    ret();
  endtask

  // ==========================================
  // main sequence
  initial begin
    {clk, reg_wr, reg_rd, handler_return, reg_addr, reg_wdata, fl} = '0;
    {en_v, pri_v, ack_wait, num_errors, checked, cyc} = '0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset_vec", vec_addr, ivps_pkg::RESET_VECTOR);
    chk("reset_req", vec_req, 1'b0);
    wr(ivps_pkg::OFS_ACTIVE_PAGE, 8'h33);
    wr(ivps_pkg::OFS_PAGE_BOTTOM, 8'h5a);
    rd(ivps_pkg::OFS_PAGE_BOTTOM);
    chk("bottom_rd", d, 8'h5a);
    {ea, el, eb} = {8'h33, 8'h00, 8'h5a};
    wr(ivps_pkg::OFS_EVT_ENABLE, 8'h01);
    @(posedge clk) fl[0] <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("masked", vec_req, 1'b0);
    @(posedge clk) fl[0] <= 1'b0;
    for (int n = 0; n < 18; n++) vec(n, FB[n]);
    vec(4, 5);
    vec(5, 7);
    vec(6, 11);
    vec(13, 19);
    rd(ivps_pkg::OFS_EVT_STATUS);
    chk("status", d, 8'h01);
    chk("irq_on", irq, 1'b1);
    wr(ivps_pkg::OFS_EVT_CLEAR, 8'h07);
    #1 chk("irq_off", irq, 1'b0);
    // two equal requests, slow core
    en_v = 18'h01080;
    cfg();
    ack_wait <= 4'hf;
    @(posedge clk) fl[17:12] <= 6'h21;
    repeat (4) @(posedge clk);
    #1 chk("tie_addr", vec_addr, 16'h003b);
    take(took_cnt, 7);
    @(posedge clk) fl[17:12] <= 6'h00;
    ret();
    // low can handler preempted by a high counter array request
    ack_wait <= 4'h0;
    en_v = 18'h10402;
    pri_v = 18'h00400;
    cfg();
    rd(ivps_pkg::OFS_EXT_PRI1);
    chk("pri_rd", d, 8'h08);
    @(posedge clk) fl[21] <= 1'b1;
    take(took_cnt, 16);
    @(posedge clk) fl[21] <= 1'b0;
    fl[1] <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("no_preempt", vec_req, 1'b0);
    @(posedge clk) fl[15] <= 1'b1;
    take(took_cnt, 10);
    chk("high", took_high, 1'b1);
    rd(ivps_pkg::OFS_SERVICE);
    chk("service", d, 8'h03);
    @(posedge clk) fl[15] <= 1'b0;
    ret();
    @(posedge clk) fl[1] <= 1'b0;
    ret();
    rd(ivps_pkg::OFS_EVT_STATUS);
    chk("preempt_evt", d, 8'h03);
    // return with nothing in service must not pop
    @(posedge clk) handler_return <= 1'b1;
    @(posedge clk) handler_return <= 1'b0;
    rd(ivps_pkg::OFS_EVT_STATUS);
    chk("stray_evt", d, 8'h07);
    pages();
    final_report();
  end
endmodule

`default_nettype wire
